// ---- bench/sscc_cmp_model.sv ----
// comparator front end seen by the sar core
// assumes trial is offset binary and p - n stays in range
module sscc_cmp_model
   import sscc_pkg::*;
(
   input  wire logic [RES_W-1:0] trial,
   input  wire logic [RES_W-1:0] in_p,
   input  wire logic [RES_W-1:0] in_n,
   output logic                  comp
);
   timeunit 1ns;
   timeprecision 100ps;
   // keep the trial bit while the trial does not exceed the difference
   assign comp = $signed(trial ^ CODE_NEG_FS) <= $signed(in_p - in_n);
endmodule // sscc_cmp_model

// ---- bench/sscc_top_monitor.sv ----
// checker on the sscc_top ports
// assumes the bench binds it onto sscc_top
module sscc_top_monitor
   import sscc_pkg::*;
(
   input wire logic          clock,
   input wire logic          rst_n,
   input wire logic          conversion_start_pin,
   input wire logic          ovr_pos,
   input wire logic          ovr_neg,
   input wire sscc_result_t  result_out,
   input wire logic          sample_p_q,
   input wire logic          sample_n_q,
   input wire logic          hold_q
);
   timeunit 1ns;
   timeprecision 100ps;
   int lo_q;
   // counts cycles with done low, so a restarted conversion overruns
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n) lo_q <= 0;
      else lo_q <= result_out.done ? 0 : lo_q + 1;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   start_conv_a: assert property ($rose(conversion_start_pin) && sample_p_q && result_out.done
      |=> !result_out.done && hold_q) else $error("start not taken");
   conv_len_a: assert property ($rose(result_out.done) && $past(hold_q)
      |-> lo_q inside {[CONV_MIN_CYC-2:CONV_MAX_CYC]}) else $error("bad length");
   mode_excl_a: assert property (sample_p_q == sample_n_q && !(hold_q && sample_p_q))
      else $error("bad mode");
   fell_hold_a: assert property ($fell(result_out.done) |-> hold_q) else $error("no hold");
   back_acq_a: assert property ($rose(result_out.done) |=> sample_p_q && !hold_q)
      else $error("no acquire");
   code_keep_a: assert property (!$rose(result_out.done) |-> $stable(result_out.code))
      else $error("code moved");
   sat_neg_a: assert property ($rose(result_out.done) && $past(hold_q) && ovr_neg
      |-> result_out.code == CODE_NEG_FS) else $error("no low clip");
   sat_pos_a: assert property ($rose(result_out.done) && $past(hold_q) && ovr_pos && !ovr_neg
      |-> result_out.code == CODE_POS_FS) else $error("no high clip");
endmodule // sscc_top_monitor

// ---- bench/sscc_top_tb.sv ----
// self-checking bench for sscc_top
// assumes the comparator model on trial_q
module sscc_top_tb
   import sscc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock = 0, rst_n = 0, st = 0, we = 0, cmp, op = 0, on = 0, sp, sn, hd;
   logic [RES_W-1:0] tr, ip = 20'h0, inn = 20'h0;
   logic [RES_W-1:0] tp [8] = '{20'h0, 20'h1, 20'h0, 20'h80001, 20'h7ffff, 20'h0, 20'h0, 20'h0};
   logic [4:0]       tm;
   sscc_ref_cfg_t    ci = 8'h00, rc;
   sscc_result_t     res;
   int fail_count = 0, num_checks = 0, cyc = 0, seed = 32'heb837398, i;
   sscc_top sscc_top_inst (.clock(clock), .rst_n(rst_n), .conversion_start_pin(st),
      .cfg_we(we), .cfg_in(ci), .comp_in(cmp), .ovr_pos(op), .ovr_neg(on), .result_out(res),
      .sample_p_q(sp), .sample_n_q(sn), .hold_q(hd), .trial_q(tr), .ref_cfg_q(rc),
      .reference_trim_offset(tm));
   sscc_cmp_model sscc_cmp_model_inst (.trial(tr), .in_p(ip), .in_n(inn), .comp(cmp));
   initial forever #5 clock = ~clock;
   always @(posedge clock) begin
      cyc++;
      if (cyc > 9000) begin
         fail_count++;
         test_done;
      end
   end
   task chk(input logic [RES_W-1:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   function logic [RES_W-1:0] want(input logic [RES_W-1:0] p, n, input logic po, ne);
      return ne ? CODE_NEG_FS : po ? CODE_POS_FS : p - n;
   endfunction
   task conv(input logic [RES_W-1:0] p, n, input logic po, ne);
      int k;
      @(posedge clock) #1;
      {ip, inn, op, on, st} = {p, n, po, ne, 1'b1};
      for (k = 0; k < 5 && res.done; k++) @(posedge clock) #1;
      chk(20'(hd), 20'h1);
      st = 0;
      // a second edge mid-conversion must not restart it
      @(posedge clock) #1 st = 1;
      for (k = 2; k < 90 && !res.done; k++) @(posedge clock) #1;
      chk(20'(k >= CONV_MIN_CYC - 1 && k <= CONV_MAX_CYC + 2), 20'h1);
      chk(res.code, want(p, n, po, ne));
      st = 0;
      repeat (2) @(posedge clock) #1;
      chk(20'(sp & sn & ~hd), 20'h1);
      $display("conversion %h ended", res.code);
   endtask
   initial begin
      repeat (10) @(posedge clock);
      #1 rst_n = 1;
      repeat (3) @(posedge clock) #1;
      chk(20'(rc), 20'h0);
      chk(20'(res.done), 20'h1);
      ci = 8'($random(seed));
      we = 1;
      @(posedge clock) #1 we = 0;
      @(posedge clock) #1;
      chk(20'(tm), 20'(ci.trim));
      for (i = 0; i < 8; i++) conv(tp[i], 20'(i == 2), i == 5 || i == 7, i >= 6);
      for (i = 0; i < 8; i++) conv(20'($signed(20'($random(seed))) >>> 1),
         20'($signed(20'($random(seed))) >>> 1), 0, 0);
      @(posedge clock) #1 st = 1;
      repeat (5) @(posedge clock);
      #1 rst_n = 0;
      #1 chk(20'({res.done, rc}), 20'h0);
      st = 0;
      repeat (10) @(posedge clock);
      #1 rst_n = 1;
      repeat (3) @(posedge clock);
      conv(20'h1, 20'h0, 0, 0);
      test_done;
   end
endmodule // sscc_top_tb
bind sscc_top sscc_top_monitor sscc_top_monitor_inst (.clock(clock), .rst_n(rst_n),
   .conversion_start_pin(conversion_start_pin), .ovr_pos(ovr_pos), .ovr_neg(ovr_neg),
   .result_out(result_out), .sample_p_q(sample_p_q), .sample_n_q(sample_n_q), .hold_q(hold_q));

// ---- logic/sscc_pkg.sv ----
// package for the sar conversion state control block
// assumes a single 100 MHz internal oscillator clock
package sscc_pkg;
   localparam int RES_W          = 20;
   localparam int RANGE_W        = 3;
   localparam int TRIM_W         = 5;
   localparam int CLK_PERIOD_NS  = 10;
   localparam int TCONV_MIN_NS   = 300;
   localparam int TCONV_MAX_NS   = 600;
   // least time rounds up, longest rounds down
   localparam int CONV_MIN_CYC   = (TCONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CONV_MAX_CYC   = TCONV_MAX_NS / CLK_PERIOD_NS;
   localparam logic [2:0] RANGE_RST = 3'h0;
   localparam logic [4:0] TRIM_RST  = 5'h00;
   localparam logic [19:0] CODE_NEG_FS = 20'h80000;
   localparam logic [19:0] CODE_POS_FS = 20'h7ffff;
   localparam logic [19:0] CODE_ZERO   = 20'h00000;

   typedef enum logic [1:0] {
      SSCC_RST  = 2'b00,
      SSCC_ACQ  = 2'b01,
      SSCC_CONV = 2'b10
   } sscc_state_t;

   typedef struct packed {
      logic        done;
      logic [19:0] code;
   } sscc_result_t;

   typedef struct packed {
      logic [2:0] range_sel;
      logic [4:0] trim;
   } sscc_ref_cfg_t;
endpackage

// ---- logic/sscc_top.sv ----
// conversion state control: reset, acquire, convert sequencing and result coding
// assumes the comparator answers each trial bit within one clock and the
// interface module delivers start and config synchronous to this clock

module sscc_top
   import sscc_pkg::*;
#(
   parameter int EXTRA_MAX = CONV_MAX_CYC - CONV_MIN_CYC - RES_W
) (
   input  wire logic                 clock,
   input  wire logic                 rst_n,
   input  wire logic                 conversion_start_pin,
   input  wire logic                 cfg_we,
   input  wire sscc_ref_cfg_t        cfg_in,
   input  wire logic                 comp_in,
   input  wire logic                 ovr_pos,
   input  wire logic                 ovr_neg,
   output sscc_result_t              result_out,
   output logic                      sample_p_q,
   output logic                      sample_n_q,
   output logic                      hold_q,
   output logic [RES_W-1:0]          trial_q,
   output sscc_ref_cfg_t             ref_cfg_q,
   output logic [TRIM_W-1:0]         reference_trim_offset
);
   // ==========================================================
   // state
   sscc_state_t        state_q;
   logic               start_d1_q;
   logic [RES_W-1:0]   sar_q;
   logic [4:0]         bit_q;
   logic [7:0]         wait_q;
   logic [7:0]         lfsr_q;
   logic               start_rise;

   function automatic logic [RES_W-1:0] sat_code(input logic [RES_W-1:0] raw,
                                                 input logic pos, input logic neg);
      if (neg)
         return CODE_NEG_FS;
      else if (pos)
         return CODE_POS_FS;
      else
         return raw ^ {1'b1, {(RES_W-1){1'b0}}};
   endfunction

   assign start_rise = conversion_start_pin & ~start_d1_q;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         start_d1_q <= 1'b0;
      else
         start_d1_q <= conversion_start_pin;
   end

   // ==========================================================
   // state machine, clocked by the internal oscillator
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= SSCC_RST;
      end else begin
         case (state_q)
            SSCC_RST:  state_q <= SSCC_ACQ;
            SSCC_ACQ:  if (start_rise) state_q <= SSCC_CONV;
            SSCC_CONV: if (bit_q == 5'h0 && wait_q == 8'h00) state_q <= SSCC_ACQ;
            default:   state_q <= SSCC_RST;
         endcase
      end
   end

   // ==========================================================
   // successive approximation, then a pseudo random settle tail
   // tail keeps duration inside the limits while varying it
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sar_q  <= '0;
         trial_q <= '0;
         bit_q  <= 5'h0;
         wait_q <= 8'h00;
         lfsr_q <= 8'h01;
      end else begin
         lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
         if (state_q == SSCC_ACQ && start_rise) begin
            // trial mirrors sar so the comparator judges the bit now under test
            sar_q  <= {1'b1, {(RES_W-1){1'b0}}};
            trial_q <= {1'b1, {(RES_W-1){1'b0}}};
            bit_q  <= 5'(RES_W);
            wait_q <= 8'(CONV_MIN_CYC - RES_W) + 8'(int'(lfsr_q) % (EXTRA_MAX + 1));
         end else if (state_q == SSCC_CONV) begin
            if (bit_q != 5'h0) begin
               // trial bit kept or dropped by comparator on the held difference
               if (!comp_in) begin
                  sar_q[bit_q-5'h1]   <= 1'b0;
                  trial_q[bit_q-5'h1] <= 1'b0;
               end
               if (bit_q > 5'h1) begin
                  sar_q[bit_q-5'h2]   <= 1'b1;
                  trial_q[bit_q-5'h2] <= 1'b1;
               end
               bit_q <= bit_q - 5'h1;
            end else if (wait_q != 8'h00) begin
               wait_q <= wait_q - 8'h01;
            end
         end
      end
   end

   // ==========================================================
   // sampling switches
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sample_p_q <= 1'b0;
         sample_n_q <= 1'b0;
         hold_q     <= 1'b0;
      end else begin
         sample_p_q <= (state_q == SSCC_ACQ) && !start_rise;
         sample_n_q <= (state_q == SSCC_ACQ) && !start_rise;
         hold_q     <= (state_q == SSCC_CONV) || start_rise;
      end
   end

   // ==========================================================
   // done status and result to the interface module
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         result_out <= '{done: 1'b0, code: CODE_ZERO};
      end else if (state_q == SSCC_ACQ && start_rise) begin
         result_out.done <= 1'b0;
      end else if (state_q == SSCC_CONV && bit_q == 5'h0 && wait_q == 8'h00) begin
         result_out.done <= 1'b1;
         result_out.code <= sat_code(sar_q, ovr_pos, ovr_neg);
      end else if (state_q == SSCC_RST) begin
         result_out.done <= 1'b1;
      end
   end

   // ==========================================================
   // reference configuration; range choice is software's job
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ref_cfg_q             <= '{range_sel: RANGE_RST, trim: TRIM_RST};
         reference_trim_offset <= TRIM_RST;
      end else begin
         if (state_q == SSCC_RST) begin
            ref_cfg_q <= '{range_sel: RANGE_RST, trim: TRIM_RST};
         end else if (cfg_we) begin
            ref_cfg_q <= cfg_in;
         end
         reference_trim_offset <= ref_cfg_q.trim;
      end
   end
   // transfer clocking is owned by the interface module
endmodule // sscc_top
